// *** core/rcs_osc_edge.sv ***
// two-flop synchroniser with edge detect for one oscillator or pin
module rcs_osc_edge (
  input wire logic clk,
  input wire logic nrst,
  input wire logic osc_i,
  output logic level_o,
  output logic edge_o
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= osc_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign level_o = s2_reg;
  assign edge_o = s2_reg ^ s3_reg;
endmodule : rcs_osc_edge

// *** core/rcs_sysclk_top.sv ***
// rc oscillator enables, trim and glitch-free system clock selection
//
// Register access over Wishbone and the address map are this design's own decisions.
module rcs_sysclk_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire rcs_pkg::rcs_strap_t strap_i,
  input wire logic cal_done_i,
  input wire logic [7:0] cal_trim_i,
  input wire logic fast_osc_i,
  input wire logic slow_osc_i,
  input wire logic ultra_osc_i,
  output logic fast_osc_en_o,
  output logic slow_osc_en_o,
  output logic ultra_osc_en_o,
  output logic [7:0] fast_trim_o,
  output logic cal_request_o,
  output logic wdt_enable_o,
  output logic port_a_line_five_input_o,
  output logic sys_clk_o,
  output logic ultra_tick_o
);
  import rcs_pkg::*;

  // oscillator and handshake synchronisers
  logic [3:0] osc_raw;
  logic [3:0] osc_level;
  logic [3:0] osc_edge;
  assign osc_raw = {cal_done_i, ultra_osc_i, slow_osc_i, fast_osc_i};

  for (genvar i = 0; i < 4; i++) begin : g_sync
    rcs_osc_edge u_edge (
      .clk(clk),
      .nrst(nrst),
      .osc_i(osc_raw[i]),
      .level_o(osc_level[i]),
      .edge_o(osc_edge[i])
    );
  end

  // strap and trim pins pass two flops
  rcs_strap_t strap1_reg;
  rcs_strap_t strap2_reg;
  logic [7:0] ctrim1_reg;
  logic [7:0] ctrim2_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strap1_reg <= '0;
      strap2_reg <= '0;
      ctrim1_reg <= 8'h00;
      ctrim2_reg <= 8'h00;
    end else begin
      strap1_reg <= strap_i;
      strap2_reg <= strap1_reg;
      ctrim1_reg <= cal_trim_i;
      ctrim2_reg <= ctrim1_reg;
    end
  end

  // registers and boot state
  rcs_boot_t boot_reg;
  rcs_boot_t boot_next;
  logic [1:0] scnt_reg;
  logic [7:0] mode_reg;
  logic [7:0] mode_next;
  logic [7:0] trim_reg;
  logic [7:0] trim_next;
  logic [7:0] tm3_reg;
  logic [7:0] tm3_next;
  logic wdt_reg;
  logic wdt_next;
  logic ack_reg;
  logic [31:0] rdat_reg;

  // wishbone decode
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire bus_wr = bus_req & wb_we_i & ack_reg & wb_sel_i[0];
  wire boot_done = (boot_reg == BOOT_RUN);
  wire wr_mode = bus_wr & (wb_adr_i == ADR_CLK_MODE) & boot_done;
  wire wr_trim = bus_wr & (wb_adr_i == ADR_TRIM) & boot_done;
  wire wr_tm3 = bus_wr & (wb_adr_i == ADR_TM3);

  // boot decisions
  wire opt_disable = (strap2_reg.cal_opt > CAL_SLOW);
  wire boot_load = (boot_reg == BOOT_LOAD);
  wire cal_take = (boot_reg == BOOT_CAL) & osc_level[3];
  wire [7:0] uncal_mode = strap2_reg.boot_fast ? MODE_UNCAL_DIV64 : MODE_UNCAL_SLOW;
  wire [7:0] boot_mode = opt_disable ? uncal_mode : rcs_boot_mode(strap2_reg.cal_opt);

  always_comb begin
    boot_next = boot_reg;
    unique case (boot_reg)
      BOOT_SYNC: boot_next = (scnt_reg == SYNC_CYCLES - 2'h1) ? BOOT_LOAD : BOOT_SYNC;
      BOOT_LOAD: boot_next = (opt_disable | strap2_reg.trimmed) ? BOOT_RUN : BOOT_CAL;
      BOOT_CAL: boot_next = osc_level[3] ? BOOT_RUN : BOOT_CAL;
      BOOT_RUN: boot_next = BOOT_RUN;
    endcase
  end

  assign mode_next = boot_load ? boot_mode : (wr_mode ? wb_dat_i[7:0] : mode_reg);
  wire trim_load = boot_load & ~opt_disable & strap2_reg.trimmed;
  assign trim_next = trim_load ? strap2_reg.trim :
                     cal_take ? ctrim2_reg :
                     wr_trim ? wb_dat_i[7:0] : trim_reg;
  assign tm3_next = wr_tm3 ? wb_dat_i[7:0] : tm3_reg;
  assign wdt_next = boot_load ? opt_disable : wdt_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      boot_reg <= BOOT_SYNC;
      scnt_reg <= 2'h0;
      mode_reg <= MODE_RST;
      trim_reg <= TRIM_RST;
      tm3_reg <= TM3_RST;
      wdt_reg <= 1'b1;
    end else begin
      boot_reg <= boot_next;
      scnt_reg <= scnt_reg + 2'h1;
      mode_reg <= mode_next;
      trim_reg <= trim_next;
      tm3_reg <= tm3_next;
      wdt_reg <= wdt_next;
    end
  end

  // oscillator enables, forced on until boot completes
  assign fast_osc_en_o = ~boot_done | mode_reg[FAST_EN_BIT];
  assign slow_osc_en_o = ~boot_done | mode_reg[SLOW_EN_BIT];
  assign ultra_osc_en_o = ~boot_done | tm3_reg[ULTRA_EN_BIT];
  assign fast_trim_o = trim_reg;
  assign cal_request_o = (boot_reg == BOOT_CAL);
  assign wdt_enable_o = wdt_reg;
  assign port_a_line_five_input_o = 1'b1;
  assign ultra_tick_o = osc_edge[2];

  // system clock generation
  rcs_sel_t sel_req;
  rcs_sel_t act_reg;
  logic [6:0] cnt_reg;
  logic sclk_reg;
  assign sel_req = rcs_decode(mode_reg);
  wire old_run = act_reg.use_slow ? slow_osc_en_o : fast_osc_en_o;
  wire new_run = sel_req.use_slow ? slow_osc_en_o : fast_osc_en_o;
  wire pending = (act_reg != sel_req);
  // a switch with the old oscillator stopped never completes
  wire do_switch = pending & old_run & new_run & ~sclk_reg;
  // boot load takes the booted selection at once: every oscillator is still forced on and the system clock is still low
  wire take_sel = do_switch | boot_load;
  rcs_sel_t sel_take;
  assign sel_take = boot_load ? rcs_decode(boot_mode) : sel_req;
  wire src_edge = act_reg.use_slow ? osc_edge[1] : osc_edge[0];
  wire half_end = (cnt_reg == act_reg.half - 7'h01);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      act_reg <= SEL_RST;
      cnt_reg <= 7'h00;
      sclk_reg <= 1'b0;
    end else if (take_sel) begin
      act_reg <= sel_take;
      cnt_reg <= 7'h00;
    end else if (src_edge) begin
      cnt_reg <= half_end ? 7'h00 : cnt_reg + 7'h01;
      sclk_reg <= half_end ? ~sclk_reg : sclk_reg;
    end
  end
  assign sys_clk_o = sclk_reg;

  // register read path
  wire [7:0] status = {2'b00, act_reg.use_slow, sclk_reg, pending, wdt_reg,
                       cal_request_o, boot_done};
  wire [7:0] rd_byte = (wb_adr_i == ADR_CLK_MODE) ? mode_reg :
                       (wb_adr_i == ADR_TRIM) ? trim_reg :
                       (wb_adr_i == ADR_TM3) ? tm3_reg :
                       (wb_adr_i == ADR_STATUS) ? status : 8'h00;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
      rdat_reg <= (bus_req & ~ack_reg) ? {24'h00_0000, rd_byte} : rdat_reg;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  fast_enable_a: assert property (wr_mode |=> fast_osc_en_o == $past(wb_dat_i[4]))
    else $error("fast enable does not follow mode bit 4");
  ultra_enable_a: assert property (
    wr_tm3 ##1 boot_done |-> ultra_osc_en_o == $past(wb_dat_i[0]))
    else $error("ultra enable does not follow timer control bit 0");
  boot_enables_a: assert property (
    !boot_done |-> fast_osc_en_o && slow_osc_en_o && ultra_osc_en_o)
    else $error("oscillator off during boot");
  trim_hold_a: assert property (boot_done && !wr_trim |=> $stable(fast_trim_o))
    else $error("trim changed without a write");
  div4_sel_a: assert property (wr_mode && wb_dat_i[7:0] == MODE_FAST_DIV4
                               |=> !sel_req.use_slow && sel_req.half == 7'h04 && fast_osc_en_o)
    else $error("14h does not select fast divided by 4");
  slow_sel_a: assert property (wr_mode && wb_dat_i[7:0] == MODE_SLOW
                               |=> sel_req.use_slow && sel_req.half == 7'h01)
    else $error("E4h does not select slow undivided");
  switch_now_a: assert property (pending && old_run && new_run && !sclk_reg
                                 |=> act_reg == $past(sel_req) && cnt_reg == 7'h00)
    else $error("switch not taken when allowed");
  no_runt_a: assert property (act_reg != $past(act_reg) |-> !$past(sclk_reg) && !sclk_reg)
    else $error("switch outside low phase");
  boot_fast_a: assert property (
    boot_load && !opt_disable && strap2_reg.cal_opt != CAL_SLOW
    |=> !wdt_enable_o && mode_reg[SLOW_EN_BIT] && mode_reg[FAST_EN_BIT])
    else $error("fast calibration boot state wrong");
  boot_slow_a: assert property (boot_load && strap2_reg.cal_opt == CAL_SLOW
                                |=> mode_reg == MODE_SLOW && !wdt_enable_o && act_reg.use_slow)
    else $error("slow calibration boot state wrong");
  boot_off_a: assert property (boot_load && opt_disable
                               |=> wdt_enable_o && trim_reg == TRIM_RST && boot_done)
    else $error("disabled calibration boot state wrong");
  cal_once_a: assert property (boot_done |=> !cal_request_o)
    else $error("calibration requested after boot");
endmodule : rcs_sysclk_top

// *** inc/rcs_pkg.sv ***
// constants, types and decode functions of the rc oscillator / system clock block
package rcs_pkg;
  localparam logic [3:0] ADR_CLK_MODE = 4'h0;
  localparam logic [3:0] ADR_TRIM = 4'h4;
  localparam logic [3:0] ADR_TM3 = 4'h8;
  localparam logic [3:0] ADR_STATUS = 4'hC;

  localparam int FAST_EN_BIT = 4;
  localparam int SLOW_EN_BIT = 2;
  localparam int ULTRA_EN_BIT = 0;

  localparam logic [7:0] MODE_FAST_DIV4 = 8'h14;
  localparam logic [7:0] MODE_FAST_DIV8 = 8'h3C;
  localparam logic [7:0] MODE_FAST_DIV16 = 8'h1C;
  localparam logic [7:0] MODE_FAST_DIV32 = 8'h7C;
  localparam logic [7:0] MODE_SLOW = 8'hE4;
  localparam logic [7:0] MODE_UNCAL_SLOW = 8'hF4;
  localparam logic [7:0] MODE_UNCAL_DIV64 = 8'h54;
  localparam logic [7:0] MODE_RST = 8'h54;
  localparam logic [7:0] TRIM_RST = 8'h80;
  localparam logic [7:0] TM3_RST = 8'h01;

  localparam logic [2:0] CAL_DIV4 = 3'h0;
  localparam logic [2:0] CAL_DIV8 = 3'h1;
  localparam logic [2:0] CAL_DIV16 = 3'h2;
  localparam logic [2:0] CAL_DIV32 = 3'h3;
  localparam logic [2:0] CAL_SLOW = 3'h4;

  localparam logic [1:0] SYNC_CYCLES = 2'h2;

  typedef enum logic [1:0] {BOOT_SYNC, BOOT_LOAD, BOOT_CAL, BOOT_RUN} rcs_boot_t;

  // half: source edges per half period of the system clock
  typedef struct packed {
    logic use_slow;
    logic [6:0] half;
  } rcs_sel_t;

  typedef struct packed {
    logic [2:0] cal_opt;
    logic boot_fast;
    logic trimmed;
    logic [7:0] trim;
  } rcs_strap_t;

  localparam rcs_sel_t SEL_RST = '{use_slow: 1'b0, half: 7'h40};

  function automatic rcs_sel_t rcs_decode(input logic [7:0] m);
    rcs_sel_t s;
    s.use_slow = m[7];
    s.half = 7'h01;
    if (!m[7]) begin
      unique case (m[6:5])
        2'b00: s.half = m[3] ? 7'h10 : 7'h04;
        2'b01: s.half = 7'h08;
        2'b10: s.half = 7'h40;
        2'b11: s.half = 7'h20;
      endcase
    end
    return s;
  endfunction : rcs_decode

  function automatic logic [7:0] rcs_boot_mode(input logic [2:0] opt);
    logic [7:0] m;
    m = MODE_FAST_DIV4;
    case (opt)
      CAL_DIV8: m = MODE_FAST_DIV8;
      CAL_DIV16: m = MODE_FAST_DIV16;
      CAL_DIV32: m = MODE_FAST_DIV32;
      CAL_SLOW: m = MODE_SLOW;
      default: m = MODE_FAST_DIV4;
    endcase
    return m;
  endfunction : rcs_boot_mode
endpackage : rcs_pkg

// *** test/rcs_sysclk_top_tb.sv ***
// self-checking testbench of the rc oscillator and system clock block
module rcs_sysclk_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rcs_pkg::*;
  logic clk, nrst, cyc, stb, we, ack, cal_done, fast_osc, slow_osc, ultra_osc;
  logic fast_en, slow_en, ultra_en, cal_req, wdt_en, pa5_in, sys_clk, utick;
  logic [3:0] adr, sel;
  logic [31:0] wdat, rdat, q;
  logic [7:0] cal_trim, trim;
  logic [2:0] fcnt, scnt, ucnt;
  rcs_strap_t strap;
  int error_cnt, checks;

  rcs_sysclk_top dut_u (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .strap_i(strap), .cal_done_i(cal_done), .cal_trim_i(cal_trim), .fast_osc_i(fast_osc),
    .slow_osc_i(slow_osc), .ultra_osc_i(ultra_osc), .fast_osc_en_o(fast_en),
    .slow_osc_en_o(slow_en), .ultra_osc_en_o(ultra_en), .fast_trim_o(trim),
    .cal_request_o(cal_req), .wdt_enable_o(wdt_en), .port_a_line_five_input_o(pa5_in),
    .sys_clk_o(sys_clk), .ultra_tick_o(utick));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // oscillators stop while disabled: fast edge every 3 cycles, slow every 7, ultra every 5
  always @(posedge clk) begin
    fcnt <= (fcnt == 3'h2) ? 3'h0 : fcnt + 3'h1;
    scnt <= (scnt == 3'h6) ? 3'h0 : scnt + 3'h1;
    ucnt <= (ucnt == 3'h4) ? 3'h0 : ucnt + 3'h1;
    if (fcnt == 3'h2 && fast_en === 1'b1) fast_osc <= ~fast_osc;
    if (scnt == 3'h6 && slow_en === 1'b1) slow_osc <= ~slow_osc;
    if (ucnt == 3'h4 && ultra_en === 1'b1) ultra_osc <= ~ultra_osc;
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [7:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 64);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 64) begin
      error_cnt++;
      wrap_up();
    end
  endtask : wb

  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    wb(1'b0, a, 4'hF, 8'h00);
    chk(q, {24'h0, exp});
  endtask : rchk

  task automatic wait_done();
    int n;
    n = 0;
    do begin
      wb(1'b0, ADR_STATUS, 4'hF, 8'h00);
      n++;
    end while (q[0] !== 1'b1 && n < 100);
    if (n >= 100) begin
      error_cnt++;
      wrap_up();
    end
  endtask : wait_done

  task automatic boot(input logic [2:0] o, input logic bf, input logic tr, input logic [7:0] t);
    nrst <= 1'b0;
    strap <= '{cal_opt: o, boot_fast: bf, trimmed: tr, trim: t};
    repeat (6) @(posedge clk);
    chk({fast_en, slow_en, ultra_en}, 32'h7);
    nrst <= 1'b1;
  endtask : boot

  // cycles between the second and third rising edge of the system clock
  task automatic period(input int exp);
    int r, t0, i;
    logic prev;
    r = 0;
    t0 = 0;
    prev = sys_clk;
    for (i = 0; i < 3000 && r < 3; i++) begin
      @(posedge clk);
      if (sys_clk === 1'b1 && prev === 1'b0) r++;
      if (r == 2 && t0 == 0) t0 = i;
      prev = sys_clk;
    end
    if (r < 3) begin
      error_cnt++;
      wrap_up();
    end
    chk(i - 1 - t0, exp);
  endtask : period

  // ultra ticks over 50 cycles, after 5 cycles for the synchroniser to settle
  task automatic ticks(input logic [31:0] exp);
    logic [31:0] n;
    n = 32'h0;
    repeat (5) @(posedge clk);
    repeat (50) begin
      @(posedge clk);
      n = n + {31'h0, utick};
    end
    chk(n, exp);
  endtask : ticks

  task automatic boot_options();
    logic [7:0] m [5] = '{8'h14, 8'h3C, 8'h1C, 8'h7C, 8'hE4};
    int p [5] = '{24, 48, 96, 192, 14};
    for (int i = 0; i < 5; i++) begin
      boot(3'(i), 1'b0, 1'b1, 8'(8'h3A + i));
      wait_done();
      rchk(ADR_CLK_MODE, m[i]);
      chk(trim, 8'(8'h3A + i));
      chk({wdt_en, slow_en, pa5_in, fast_en}, {28'h0, 3'b011, i != 4});
      period(p[i]);
    end
    for (int b = 0; b < 2; b++) begin
      boot(3'h5, b[0], 1'b0, 8'h3A);
      wait_done();
      rchk(ADR_CLK_MODE, b[0] ? 8'h54 : 8'hF4);
      chk({wdt_en, trim}, 32'h180);
      period(b[0] ? 384 : 14);
    end
  endtask : boot_options

  task automatic calibrate_once();
    boot(CAL_DIV4, 1'b0, 1'b0, 8'h11);
    repeat (10) @(posedge clk);
    chk(cal_req, 32'h1);
    cal_trim <= 8'h5A;
    cal_done <= 1'b1;
    wait_done();
    chk({cal_req, trim}, 32'h05A);
    cal_done <= 1'b0;
    boot(CAL_DIV4, 1'b0, 1'b1, 8'h11);
    wait_done();
    chk({cal_req, trim}, 32'h011);
  endtask : calibrate_once

  task automatic switching();
    logic [7:0] m [10] = '{8'h3C, 8'h1C, 8'h7C, 8'h14, 8'h10, 8'h14, 8'hF4, 8'hE4, 8'hF4, 8'h3C};
    int p [10] = '{48, 96, 192, 24, 24, 24, 14, 14, 14, 48};
    for (int i = 0; i < 10; i++) begin
      wb(1'b1, ADR_CLK_MODE, 4'hF, m[i]);
      rchk(ADR_CLK_MODE, m[i]);
      chk({fast_en, slow_en}, {30'h0, m[i][4], m[i][2]});
      period(p[i]);
    end
  endtask : switching

  task automatic registers();
    rchk(ADR_TM3, 8'h01);
    wb(1'b1, ADR_TM3, 4'hF, 8'h00);
    rchk(ADR_TM3, 8'h00);
    chk({ultra_en, fast_en, slow_en}, 32'h3);
    ticks(32'h0);
    wb(1'b1, ADR_TM3, 4'hF, 8'h01);
    rchk(ADR_TM3, 8'h01);
    chk(ultra_en, 32'h1);
    ticks(32'hA);
    wb(1'b1, ADR_TRIM, 4'hF, 8'hA5);
    rchk(ADR_TRIM, 8'hA5);
    chk(trim, 32'hA5);
    wb(1'b1, ADR_TRIM, 4'hE, 8'h5C);
    rchk(ADR_TRIM, 8'hA5);
    wb(1'b1, 4'h2, 4'hF, 8'hFF);
    rchk(4'h2, 8'h00);
  endtask : registers

  initial begin
    {nrst, cyc, stb, we, cal_done, fast_osc, slow_osc, ultra_osc} = '0;
    {fcnt, scnt, ucnt} = '0;
    adr = 4'h0;
    sel = 4'hF;
    wdat = 32'h0;
    cal_trim = 8'h00;
    strap = '0;
    error_cnt = 0;
    checks = 0;
    boot_options();
    calibrate_once();
    switching();
    registers();
    wrap_up();
  end
endmodule : rcs_sysclk_top_tb
